// >>> srfc_ctrl_model.sv
// External controller model driving the pin command lines
`timescale 1ns/10ps
module srfc_ctrl_model import srfc_pkg::*; (
  // Clock
  input wire logic clk,
  // Commands to the supervisor
  output srfc_cmd_type pin_cmd
);
  logic hold_stop = 1'b0;
  logic [2:0] pulse_bits = 3'h0;
  assign pin_cmd = pulse_bits | {1'b0, hold_stop, 1'b0};
  // Momentary pulse, one cycle high then low
  task automatic pulse(input logic [2:0] bits);
    @(posedge clk);
    #1 pulse_bits = bits;
    @(posedge clk);
    #1 pulse_bits = 3'h0;
  endtask
endmodule

// >>> srfc_pkg.sv
// Types for the supply run and fault supervisor
package srfc_pkg;
  typedef enum logic [1:0] {
    SRFC_STANDBY,
    SRFC_RUN,
    SRFC_FAULT
  } srfc_state_type;
  typedef struct packed {
    logic start;
    logic stop;
    logic clear;
  } srfc_cmd_type;
  typedef struct packed {
    logic safety_loop_ok;
    logic overcurrent;
    logic overvoltage;
    logic setpoint_range;
    logic secondary_overcurrent;
    logic over_temperature;
    logic protector_open;
    logic mains_problem;
    logic current_mode;
  } srfc_sense_type;
endpackage

// >>> srfc_regs.svh
// Constants for the supply run and fault supervisor
`ifndef SRFC_REGS_SVH
`define SRFC_REGS_SVH
`define SRFC_CMD_SRC_PIN 1'b1
`define SRFC_CMD_SRC_PANEL 1'b0
`define SRFC_STANDBY_RESET 1'b1
`endif

// >>> srfc_top.sv
// Run-state and fault supervisor for the rear-panel digital control port
`timescale 1ns/10ps
`include "srfc_regs.svh"
// Contract
// - Start closes contactor, enables output, ramps to set points.
// - Stop opens contactor, disables output, ramps to zero.
// - Clear resets latched faults and returns to standby, not run.
// - Safety loop lost while output enabled enters loop fault, opens contactor.
// - After loop fault, starts are ignored until cleared.
// - Safety loop input acts only when the loop function is enabled.
// - Status outputs are high when active, low when inactive.
// - Output-on status whenever the output is enabled.
// - Loop fault status holds until loop restored and clear accepted.
// - Off-or-alarm status in standby or any alarm state.
// - Alarm status while a fault is latched; no re-enable until cleared; the code does not raise it for a latched set-point range fault.
// - Pin or panel command source status follows the active source.
// - Set-point range fault asserts status, disables supply, enters standby.
// - Over-current trip asserts status and latches a fault shutdown.
// - Over-voltage trip asserts status and latches a fault shutdown.
// - Clear is accepted only from the active command source.
// - After a cleared trip a new start is needed; no self restart.
// - Secondary over-current is cleared only by power cycling.
// - Standby status while powered with output disabled; the code shows it only in SRFC_STANDBY with no alarm latched.
// - Current and voltage regulation status follow control mode.
// - Over-temperature status follows the thermal report, self resetting.
// - Protector-open status when fuse or breaker reports open.
// - Mains fault status when the mains monitor reports trouble.
// - A held external stop overrides the external start.
// - Diagnostic indications latch until clear or power cycle.
module srfc_top import srfc_pkg::*; (
  // Clock and reset
  input wire logic clk,
  input wire logic rstn,
  // Configuration
  input wire logic pin_source_sel,
  input wire logic safety_loop_enable,
  // Commands
  input wire srfc_cmd_type pin_cmd,
  input wire srfc_cmd_type panel_cmd,
  // Sensed conditions
  input wire srfc_sense_type sense,
  // Power stage controls
  output logic contactor_close,
  output logic output_enable,
  // Status
  output logic output_on_out,
  output logic standby_out,
  output logic off_or_alarm_out,
  output logic fault_alarm_out,
  output logic safety_loop_fault,
  output logic setpoint_range_out,
  output logic overcurrent_trip_out,
  output logic overvoltage_trip_out,
  output logic over_temperature_out,
  output logic protector_open_out,
  output logic mains_fault_out,
  output logic current_regulation_out,
  output logic voltage_regulation_out,
  output logic pin_command_source_out,
  output logic panel_command_source_out
);
  // ****************************************
  // Command synchronisers and edge detect
  // ****************************************
  srfc_cmd_type pin_s1, pin_s2, pin_s3;
  srfc_cmd_type pan_s1, pan_s2, pan_s3;
  always_ff @(posedge clk) begin
    if (!rstn) begin
      pin_s1 <= '0;
      pin_s2 <= '0;
      pin_s3 <= '0;
      pan_s1 <= '0;
      pan_s2 <= '0;
      pan_s3 <= '0;
    end else begin
      pin_s1 <= pin_cmd;
      pin_s2 <= pin_s1;
      pin_s3 <= pin_s2;
      pan_s1 <= panel_cmd;
      pan_s2 <= pan_s1;
      pan_s3 <= pan_s2;
    end
  end
  wire srfc_cmd_type pin_edge = pin_s2 & ~pin_s3;
  wire srfc_cmd_type pan_edge = pan_s2 & ~pan_s3;
  wire use_pin = (pin_source_sel == `SRFC_CMD_SRC_PIN);
  wire srfc_cmd_type act_edge = use_pin ? pin_edge : pan_edge;
  wire stop_level = use_pin ? pin_s2.stop : pan_s2.stop;
  wire do_stop = act_edge.stop;
  wire do_clear = act_edge.clear;
  wire do_start = act_edge.start & ~stop_level;
  // ****************************************
  // Fault latches
  // ****************************************
  srfc_state_type state;
  srfc_state_type next_state;
  logic loop_lat, oc_lat, ov_lat, pgl_lat, sec_lat;
  wire loop_event = safety_loop_enable & ~sense.safety_loop_ok & output_enable;
  wire oc_event = sense.overcurrent & output_enable;
  wire ov_event = sense.overvoltage & output_enable;
  wire pgl_event = sense.setpoint_range;
  wire loop_restored = ~safety_loop_enable | sense.safety_loop_ok;
  wire clr_loop = do_clear & loop_restored;
  wire next_loop = loop_event | (loop_lat & ~clr_loop);
  wire next_oc = oc_event | (oc_lat & ~do_clear);
  wire next_ov = ov_event | (ov_lat & ~do_clear);
  wire next_pgl = pgl_event | (pgl_lat & ~do_clear);
  wire next_sec = sense.secondary_overcurrent | sec_lat;
  wire trip_event = loop_event | oc_event | ov_event | sense.secondary_overcurrent;
  wire any_alarm = next_loop | next_oc | next_ov | next_sec;
  wire next_prot = sense.protector_open | (protector_open_out & ~do_clear);
  wire next_mains = sense.mains_problem | (mains_fault_out & ~do_clear);
  // ****************************************
  // Run state machine
  // ****************************************
  always_comb begin
    next_state = state;
    unique case (state)
      SRFC_STANDBY: begin
        if (do_start && !any_alarm && !next_pgl) begin
          next_state = SRFC_RUN;
        end
      end
      SRFC_RUN: begin
        if (trip_event) begin
          next_state = SRFC_FAULT;
        end else if (do_stop || pgl_event) begin
          next_state = SRFC_STANDBY;
        end
      end
      SRFC_FAULT: begin
        if (!any_alarm) begin
          next_state = SRFC_STANDBY;
        end
      end
    endcase
  end
  always_ff @(posedge clk) begin
    if (!rstn) begin
      state <= SRFC_STANDBY;
      loop_lat <= 1'b0;
      oc_lat <= 1'b0;
      ov_lat <= 1'b0;
      pgl_lat <= 1'b0;
      sec_lat <= 1'b0;
    end else begin
      state <= next_state;
      loop_lat <= next_loop;
      oc_lat <= next_oc;
      ov_lat <= next_ov;
      pgl_lat <= next_pgl;
      sec_lat <= next_sec;
    end
  end
  // ****************************************
  // Registered outputs
  // ****************************************
  wire next_run = (next_state == SRFC_RUN);
  wire next_fault_alarm = any_alarm | (next_state == SRFC_FAULT);
  always_ff @(posedge clk) begin
    if (!rstn) begin
      contactor_close <= 1'b0;
      output_enable <= 1'b0;
      output_on_out <= 1'b0;
      standby_out <= `SRFC_STANDBY_RESET;
      off_or_alarm_out <= `SRFC_STANDBY_RESET;
      fault_alarm_out <= 1'b0;
      safety_loop_fault <= 1'b0;
      setpoint_range_out <= 1'b0;
      overcurrent_trip_out <= 1'b0;
      overvoltage_trip_out <= 1'b0;
      over_temperature_out <= 1'b0;
      protector_open_out <= 1'b0;
      mains_fault_out <= 1'b0;
      current_regulation_out <= 1'b0;
      voltage_regulation_out <= 1'b0;
      pin_command_source_out <= 1'b0;
      panel_command_source_out <= 1'b0;
    end else begin
      contactor_close <= next_run;
      output_enable <= next_run;
      output_on_out <= next_run;
      standby_out <= (next_state == SRFC_STANDBY) & ~next_fault_alarm;
      off_or_alarm_out <= ~next_run;
      fault_alarm_out <= next_fault_alarm;
      safety_loop_fault <= next_loop;
      setpoint_range_out <= next_pgl;
      overcurrent_trip_out <= next_oc | next_sec;
      overvoltage_trip_out <= next_ov;
      over_temperature_out <= sense.over_temperature;
      protector_open_out <= next_prot;
      mains_fault_out <= next_mains;
      current_regulation_out <= next_run & sense.current_mode;
      voltage_regulation_out <= next_run & ~sense.current_mode;
      pin_command_source_out <= use_pin;
      panel_command_source_out <= ~use_pin;
    end
  end
  // ****************************************
  // Assertions
  // ****************************************
  a_start_runs: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_STANDBY && do_start && !any_alarm && !next_pgl) |=> output_enable)
    else $error("start did not enable output");
  a_stop_halts: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_RUN && do_stop) |=> !output_enable && !contactor_close)
    else $error("stop did not disable output");
  a_clear_standby: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_FAULT && do_clear) |=> state != SRFC_RUN)
    else $error("clear went to run");
  a_loop_trip: assert property (@(posedge clk) disable iff (!rstn)
    loop_event |=> safety_loop_fault && !contactor_close)
    else $error("loop loss not handled");
  a_loop_blocks: assert property (@(posedge clk) disable iff (!rstn)
    safety_loop_fault |=> !output_enable)
    else $error("start accepted during loop fault");
  a_loop_disabled: assert property (@(posedge clk) disable iff (!rstn)
    !safety_loop_enable && !loop_lat |=> !safety_loop_fault)
    else $error("loop input acted while disabled");
  a_on_status: assert property (@(posedge clk) disable iff (!rstn)
    output_on_out == output_enable)
    else $error("output-on status mismatch");
  a_off_alarm: assert property (@(posedge clk) disable iff (!rstn)
    off_or_alarm_out == !output_enable)
    else $error("off-or-alarm mismatch");
  a_oc_latch: assert property (@(posedge clk) disable iff (!rstn)
    oc_event ##1 !do_clear |=> overcurrent_trip_out)
    else $error("over-current not latched");
  a_sec_stays: assert property (@(posedge clk) disable iff (!rstn)
    sec_lat |=> sec_lat)
    else $error("secondary over-current cleared");
  a_stop_wins: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_STANDBY && stop_level) |=> !output_enable)
    else $error("start taken while stop held");
  sequence s_start_taken;
    state == SRFC_STANDBY && do_start && !any_alarm && !next_pgl;
  endsequence
  sequence s_running;
    output_enable && contactor_close && output_on_out && !off_or_alarm_out && !standby_out;
  endsequence
  sequence s_tripped;
    !output_enable && !contactor_close && fault_alarm_out;
  endsequence
  sequence s_pin_start_rise;
    !pin_cmd.start ##1 pin_cmd.start;
  endsequence
  a_start_walk: assert property (@(posedge clk) disable iff (!rstn)
    s_start_taken |=> s_running)
    else $error("start walk incomplete");
  a_trip_walk: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_RUN && trip_event) |=> s_tripped)
    else $error("trip did not shut down");
  a_clear_returns: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_FAULT && do_clear && !next_loop && !next_sec) |=>
      state == SRFC_STANDBY && !fault_alarm_out)
    else $error("clear did not return to standby");
  a_ov_latch: assert property (@(posedge clk) disable iff (!rstn)
    ov_event |=> overvoltage_trip_out && !output_enable)
    else $error("over-voltage not latched");
  a_loop_hold: assert property (@(posedge clk) disable iff (!rstn)
    (loop_lat && !clr_loop) |=> safety_loop_fault)
    else $error("loop fault dropped early");
  a_alarm_blocks: assert property (@(posedge clk) disable iff (!rstn)
    fault_alarm_out |=> !output_enable)
    else $error("output enabled under alarm");
  a_src_pin: assert property (@(posedge clk) disable iff (!rstn)
    use_pin |=> pin_command_source_out && !panel_command_source_out)
    else $error("pin source status wrong");
  a_src_panel: assert property (@(posedge clk) disable iff (!rstn)
    !use_pin |=> panel_command_source_out && !pin_command_source_out)
    else $error("panel source status wrong");
  a_range_standby: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_RUN && pgl_event && !trip_event) |=>
      state == SRFC_STANDBY && setpoint_range_out && !output_enable)
    else $error("range fault not handled");
  a_clear_source: assert property (@(posedge clk) disable iff (!rstn)
    (use_pin && pan_edge.clear && !pin_edge.clear && oc_lat) |=> overcurrent_trip_out)
    else $error("clear taken from inactive source");
  a_no_restart: assert property (@(posedge clk) disable iff (!rstn)
    (state == SRFC_STANDBY && !do_start) |=> !output_enable)
    else $error("output enabled without start");
  a_standby_off: assert property (@(posedge clk) disable iff (!rstn)
    standby_out |-> !output_enable && !contactor_close)
    else $error("standby status with output on");
  a_reg_mode: assert property (@(posedge clk) disable iff (!rstn)
    output_enable |-> (current_regulation_out != voltage_regulation_out))
    else $error("regulation status not exclusive");
  a_reg_idle: assert property (@(posedge clk) disable iff (!rstn)
    !output_enable |-> !current_regulation_out && !voltage_regulation_out)
    else $error("regulation status while off");
  a_thermal_on: assert property (@(posedge clk) disable iff (!rstn)
    sense.over_temperature |=> over_temperature_out)
    else $error("over-temperature not shown");
  a_thermal_off: assert property (@(posedge clk) disable iff (!rstn)
    !sense.over_temperature |=> !over_temperature_out)
    else $error("over-temperature did not reset");
  a_prot_latch: assert property (@(posedge clk) disable iff (!rstn)
    sense.protector_open |=> protector_open_out)
    else $error("protector open not shown");
  a_mains_latch: assert property (@(posedge clk) disable iff (!rstn)
    sense.mains_problem |=> mains_fault_out)
    else $error("mains fault not shown");
  a_diag_hold: assert property (@(posedge clk) disable iff (!rstn)
    (mains_fault_out && !do_clear) |=> mains_fault_out)
    else $error("mains fault dropped before clear");
  a_prot_hold: assert property (@(posedge clk) disable iff (!rstn)
    (protector_open_out && !do_clear) |=> protector_open_out)
    else $error("protector status dropped before clear");
  a_sync_delay: assert property (@(posedge clk) disable iff (!rstn)
    s_pin_start_rise |-> ##2 pin_edge.start)
    else $error("start edge not seen after sync");
  a_edge_once: assert property (@(posedge clk) disable iff (!rstn)
    pin_edge.start |=> !pin_edge.start)
    else $error("start edge acted twice");
endmodule

// >>> supply_run_fault_control_test.sv
// Self-checking bench for the run and fault supervisor
`timescale 1ns/10ps
module supply_run_fault_control_test import srfc_pkg::*;;
  logic clk = 1'b0, rstn = 1'b0, pin_src = 1'b1, loop_en = 1'b0;
  srfc_cmd_type panel_cmd = 3'h0;
  srfc_cmd_type pin_cmd;
  srfc_sense_type sense = 9'h100;
  logic cc, oe, on, sb, oa, fa, lf, sr, oc, ov, ot, po, mf, cr, vr, ps, pp;
  int miscompares = 0, checks = 0, cycles = 0;
  srfc_ctrl_model m_u (.clk(clk), .pin_cmd(pin_cmd));
  srfc_top dut_u (.clk(clk), .rstn(rstn), .pin_source_sel(pin_src),
    .safety_loop_enable(loop_en), .pin_cmd(pin_cmd), .panel_cmd(panel_cmd), .sense(sense),
    .contactor_close(cc), .output_enable(oe), .output_on_out(on), .standby_out(sb),
    .off_or_alarm_out(oa), .fault_alarm_out(fa), .safety_loop_fault(lf),
    .setpoint_range_out(sr), .overcurrent_trip_out(oc), .overvoltage_trip_out(ov),
    .over_temperature_out(ot), .protector_open_out(po), .mains_fault_out(mf),
    .current_regulation_out(cr), .voltage_regulation_out(vr),
    .pin_command_source_out(ps), .panel_command_source_out(pp));
  initial begin
    forever #5 clk = !clk;
  end
  // *****
  // Helpers
  // *****
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    checks++;
    if (got !== exp) begin
      miscompares++;
      $display("wrong value at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask
  // Pulse on one source, return once the output register has answered
  task automatic cmd(input logic src, input logic [2:0] bits);
    if (src) begin
      m_u.pulse(bits);
    end else begin
      @(posedge clk);
      #1 panel_cmd = bits;
      @(posedge clk);
      #1 panel_cmd = 3'h0;
    end
    tick(2);
  endtask
  task automatic conclude;
    $display("checks %0d miscompares %0d", checks, miscompares);
    if (miscompares == 0 && checks > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask
  // *****
  // Scenarios
  // *****
  task automatic t_basic(input logic src);
    pin_src = src;
    cmd(src, 3'h4);
    chk({cc, oe, on, oa, sb, vr, ps, pp}, {5'h1C, 1'b1, src, !src});
    cmd(!src, 3'h2);
    chk(oe, 1'b1);
    cmd(src, 3'h2);
    chk({cc, oe, on, oa, sb, vr, ps, pp}, {5'h03, 1'b0, src, !src});
  endtask
  task automatic t_stop_held;
    pin_src = 1'b1;
    m_u.hold_stop = 1'b1;
    cmd(1'b1, 3'h4);
    chk(oe, 1'b0);
    m_u.hold_stop = 1'b0;
    tick(2);
  endtask
  task automatic t_trip(input int idx, input logic [1:0] exp2);
    cmd(1'b1, 3'h4);
    sense[idx] = 1'b1;
    tick(1);
    chk({oe, cc, fa, oa, oc, ov}, {4'h3, exp2});
    sense[idx] = 1'b0;
    cmd(1'b1, 3'h4);
    chk(oe, 1'b0);
    cmd(1'b0, 3'h1);
    chk({fa, oc, ov}, {1'b1, exp2});
    cmd(1'b1, 3'h1);
    chk({oe, fa, sb, oc, ov}, 5'h04);
    tick(4);
    chk(oe, 1'b0);
    cmd(1'b1, 3'h4);
    chk(oe, 1'b1);
    cmd(1'b1, 3'h2);
  endtask
  task automatic t_loop;
    loop_en = 1'b1;
    cmd(1'b1, 3'h4);
    sense.safety_loop_ok = 1'b0;
    tick(1);
    chk({lf, cc, oe, fa}, 4'h9);
    cmd(1'b1, 3'h1);
    chk(lf, 1'b1);
    cmd(1'b1, 3'h4);
    chk(oe, 1'b0);
    sense.safety_loop_ok = 1'b1;
    cmd(1'b1, 3'h1);
    chk({lf, fa}, 2'h0);
    loop_en = 1'b0;
    cmd(1'b1, 3'h4);
    sense.safety_loop_ok = 1'b0;
    tick(2);
    chk(oe, 1'b1);
    sense.safety_loop_ok = 1'b1;
    cmd(1'b1, 3'h2);
  endtask
  task automatic t_range;
    cmd(1'b1, 3'h4);
    sense.setpoint_range = 1'b1;
    tick(1);
    chk({sr, oe, sb, fa}, 4'hA);
    sense.setpoint_range = 1'b0;
    cmd(1'b1, 3'h4);
    chk({sr, oe}, 2'h2);
    cmd(1'b1, 3'h1);
    chk(sr, 1'b0);
  endtask
  task automatic t_misc;
    sense[3:0] = 4'hF;
    cmd(1'b1, 3'h4);
    chk({ot, po, mf, cr, vr}, 5'h1E);
    sense[3:1] = 3'h0;
    tick(1);
    chk(ot, 1'b0);
    chk({po, mf}, 2'h3);
    cmd(1'b1, 3'h1);
    chk({ot, po, mf, oe}, 4'h1);
    sense.current_mode = 1'b0;
    cmd(1'b1, 3'h2);
  endtask
  task automatic t_secondary;
    cmd(1'b1, 3'h4);
    sense.secondary_overcurrent = 1'b1;
    tick(1);
    chk({oc, oe}, 2'h2);
    sense.secondary_overcurrent = 1'b0;
    cmd(1'b1, 3'h1);
    chk(oc, 1'b1);
    rstn = 1'b0;
    tick(2);
    rstn = 1'b1;
    tick(1);
    chk(oc, 1'b0);
  endtask
  always @(posedge clk) begin
    cycles++;
    if (cycles == 3000) begin
      miscompares++;
      $display("wrong value at %0t: run timed out", $time);
      conclude();
    end
  end
  initial begin
    repeat (5) @(posedge clk);
    #1 rstn = 1'b1;
    tick(1);
    t_basic(1'b1);
    t_basic(1'b0);
    t_stop_held();
    t_trip(7, 2'h2);
    t_trip(6, 2'h1);
    t_loop();
    t_range();
    t_misc();
    t_secondary();
    conclude();
  end
endmodule
